// *** design/pin_mux.sv ***
// Pin function selection for shared segment and common pins
`timescale 1ns/10ps
module pin_mux
(
  input  wire logic [supply_bias_pkg::MuxW-1:0] multiplexMode,
  input  wire logic [supply_bias_pkg::SegW-1:0] segmentPinSelect,
  input  wire logic [supply_bias_pkg::SegW-1:0] sharedMask,
  output logic      [supply_bias_pkg::SegW-1:0] segFunction,
  output logic      [2:0]                       comFunction
);
  import supply_bias_pkg::*;

  // Common lines 1..3 needed by the mux mode
  always_comb
  begin
    comFunction = 3'h0;
    unique case (multiplexMode)
      MuxStatic: comFunction = 3'h0;
      Mux2:      comFunction = 3'h1;
      Mux3:      comFunction = 3'h3;
      Mux4:      comFunction = 3'h7;
    endcase
  end

  // Dedicated pins always segment; shared ones follow select; commons override
  always_comb
  begin
    segFunction = ~sharedMask | (sharedMask & segmentPinSelect);
    segFunction[ComSegLsb +: 3] = segFunction[ComSegLsb +: 3] & ~comFunction;
  end

endmodule // pin_mux

// *** design/pump_guard.sv ***
// Charge pump run decision and the sticky missing-capacitor flag
`timescale 1ns/10ps
module pump_guard
(
  input  wire logic                                core_clk,
  input  wire logic                                resetn,
  input  wire logic                                genEnable,
  input  wire logic                                extSupply,
  input  wire logic                                pumpEnableCfg,
  input  wire logic                                pumpRunEnable,
  input  wire logic [supply_bias_pkg::LevelW-1:0]  pumpVoltageLevel,
  input  wire logic [supply_bias_pkg::SuspendW-1:0] suspendSel,
  input  wire logic [supply_bias_pkg::SuspendW-1:0] suspendPeriod,
  input  wire logic                                capSense,
  input  wire logic                                flagClear,
  output logic                                     pumpOn,
  output logic                                     missingCapFlag
);
  import supply_bias_pkg::*;

  typedef struct packed
  {
    logic capSync1;
    logic capSync2;
    logic flag;
  } state_t;

  state_t stateQ;
  state_t stateD;
  logic   pumpWanted;

  // Pump requested before the capacitor guard
  // run enable and suspend
  assign pumpWanted = genEnable && !extSupply && pumpEnableCfg && pumpRunEnable
                      && (pumpVoltageLevel != '0) && ((suspendSel & suspendPeriod) == '0);

  // Flag set wins over a software clear in the same cycle
  always_comb
  begin
    stateD = stateQ;
    stateD.capSync1 = capSense;
    stateD.capSync2 = stateQ.capSync1;
    if (flagClear)
    begin
      stateD.flag = 1'b0;
    end
    if (pumpWanted && !stateQ.capSync2)
    begin
      stateD.flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      stateQ <= '0;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  assign pumpOn = pumpWanted && stateQ.capSync2 && !stateQ.flag;
  assign missingCapFlag = stateQ.flag;

  // Flag keeps the pump off until software clears it
  AST_NOCAP_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    stateQ.flag |-> !pumpOn)
    else $error("pump runs while capacitor flag set");
  // Missing capacitor seen while the pump is requested is flagged one edge later
  AST_NOCAP_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    (pumpWanted && !stateQ.capSync2) |=> stateQ.flag)
    else $error("missing capacitor not flagged");
  // Run enable low stops the pump
  AST_RUN_GATE: assert property (@(posedge core_clk) disable iff (!resetn)
    !pumpRunEnable |-> !pumpOn)
    else $error("pump runs with run enable low");
  // Selected suspend period stops the pump
  AST_SUSPEND: assert property (@(posedge core_clk) disable iff (!resetn)
    ((suspendSel & suspendPeriod) != '0) |-> !pumpOn)
    else $error("pump runs in suspended period");
endmodule // pump_guard

// *** design/supply_bias_ctrl.sv ***
// Top: APB registers and supply, bias and pin-function selection
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module supply_bias_ctrl
(
  input  wire logic                                 core_clk,
  input  wire logic                                 resetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [supply_bias_pkg::AddrW-1:0]    paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 oscDisabled,
  input  wire logic                                 capSense,
  input  wire logic [supply_bias_pkg::SuspendW-1:0] suspendPeriod,
  input  wire logic [supply_bias_pkg::SegW-1:0]     sharedMask,
  output logic                                      supplyFromMain,
  output logic                                      supplyFromPump,
  output logic                                      supplyFromCapPin,
  output logic                                      pumpOn,
  output logic [supply_bias_pkg::LevelW-1:0]        pumpLevelOut,
  output logic                                      pumpRefExternal,
  output logic                                      biasGenOn,
  output logic                                      biasHalf,
  output logic                                      biasPinsOut,
  output logic                                      biasPinsIn,
  output logic                                      lowBiasExternal,
  output logic                                      ladderTopDrive,
  output logic                                      ladderTopInput,
  output logic [supply_bias_pkg::SegW-1:0]          segFunction,
  output logic [2:0]                                comFunction,
  output logic                                      missingCapFlag,
  output logic                                      missingCapIrq
);
  import supply_bias_pkg::*;

  typedef struct packed
  {
    logic        osc1;
    logic        osc2;
    logic [31:0] ctrl;
    logic [SuspendW-1:0] suspendSel;
    logic [SegW-1:0]     segSel;
    logic [31:0] rdata;
  } state_t;

  state_t stateQ;
  state_t stateD;

  logic                displayModuleOn;
  logic                externalSupplySelect;
  logic                pumpEnableCfg;
  logic                biasOutputEnable;
  logic                externalBiasEnable;
  logic                lowBiasExt;
  logic                halfBiasSelect;
  logic                missingCapIrqEnable;
  logic [MuxW-1:0]     multiplexMode;
  logic [LevelW-1:0]   pumpVoltageLevel;
  logic [RefW-1:0]     referenceSelect;
  logic [RefW-1:0]     pumpReferenceSelect;
  logic                genEnable;
  logic                pumpRunEnable;
  logic                access;
  logic                flagClear;
  logic                knownAddr;

  // Field extraction from the control word
  assign displayModuleOn      = stateQ.ctrl[CtrlModuleOnBit];
  assign externalSupplySelect = stateQ.ctrl[CtrlExtSupBit];
  assign pumpEnableCfg        = stateQ.ctrl[CtrlPumpEnBit];
  assign biasOutputEnable     = stateQ.ctrl[CtrlBiasOutBit];
  assign externalBiasEnable   = stateQ.ctrl[CtrlExtBiasBit];
  assign lowBiasExt           = stateQ.ctrl[CtrlLowExtBit];
  assign halfBiasSelect       = stateQ.ctrl[CtrlHalfBiasBit];
  assign missingCapIrqEnable  = stateQ.ctrl[CtrlCapIeBit];
  assign multiplexMode        = stateQ.ctrl[CtrlMuxLsb +: MuxW];
  assign pumpVoltageLevel     = stateQ.ctrl[CtrlLevelLsb +: LevelW];
  assign referenceSelect      = stateQ.ctrl[CtrlRefLsb +: RefW];
  assign pumpReferenceSelect  = stateQ.ctrl[CtrlPumpRefLsb +: RefW];
  assign pumpRunEnable        = pumpEnableCfg;

  // Bus decode; single-cycle answer, no wait states
  assign access    = psel && penable;
  assign knownAddr = (paddr == OffCtrl) || (paddr == OffPump) ||
                     (paddr == OffSegSel) || (paddr == OffStatus);
  assign pready    = 1'b1;
  assign pslverr   = access && !knownAddr;
  assign prdata    = stateQ.rdata;
  // Writing a one to the flag bit of status clears it
  assign flagClear = access && pwrite && (paddr == OffStatus) && pwdata[StatCapFlagBit];

  // Register writes and read data capture
  always_comb
  begin
    stateD = stateQ;
    stateD.osc1 = oscDisabled;
    stateD.osc2 = stateQ.osc1;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OffCtrl:   stateD.rdata = stateQ.ctrl;
        OffPump:   stateD.rdata = {{(32-SuspendW){1'b0}}, stateQ.suspendSel};
        OffSegSel: stateD.rdata = stateQ.segSel;
        OffStatus: stateD.rdata = {29'h0000_0000, genEnable, pumpOn, missingCapFlag};
        default:   stateD.rdata = ResetWord;
      endcase
    end
    if (access && pwrite)
    begin
      unique case (paddr)
        OffCtrl:   stateD.ctrl = pwdata;
        OffPump:   stateD.suspendSel = pwdata[SuspendW-1:0];
        OffSegSel: stateD.segSel = pwdata;
        default:   stateD.ctrl = stateQ.ctrl;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      stateQ <= '0;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  // generation gated by clock and enable
  assign genEnable = displayModuleOn && !stateQ.osc2;

  pump_guard u_pump
  (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .genEnable        (genEnable),
    .extSupply        (externalSupplySelect),
    .pumpEnableCfg    (pumpEnableCfg),
    .pumpRunEnable    (pumpRunEnable),
    .pumpVoltageLevel (pumpVoltageLevel),
    .suspendSel       (stateQ.suspendSel),
    .suspendPeriod    (suspendPeriod),
    .capSense         (capSense),
    .flagClear        (flagClear),
    .pumpOn           (pumpOn),
    .missingCapFlag   (missingCapFlag)
  );

  // Peak voltage source selection
  // main supply
  assign supplyFromMain   = !externalSupplySelect && (pumpVoltageLevel == '0)
                            && (referenceSelect == '0);
  assign supplyFromPump   = pumpOn;
  assign supplyFromCapPin = externalSupplySelect;
  assign pumpLevelOut     = pumpVoltageLevel;
  assign pumpRefExternal  = pumpOn && (pumpReferenceSelect == PumpRefExt)
                            && !biasOutputEnable && !externalBiasEnable;

  // Bias network
  // internal divider gating
  assign biasGenOn       = genEnable && !externalBiasEnable && (multiplexMode != MuxStatic);
  assign biasHalf        = halfBiasSelect;
  assign biasPinsOut     = biasOutputEnable && biasGenOn;
  assign biasPinsIn      = externalBiasEnable;
  assign lowBiasExternal = lowBiasExt;
  assign ladderTopDrive  = externalBiasEnable && !externalSupplySelect && genEnable;
  assign ladderTopInput  = externalBiasEnable && externalSupplySelect;

  assign missingCapIrq = missingCapFlag && missingCapIrqEnable;

  pin_mux u_pins
  (
    .multiplexMode    (multiplexMode),
    .segmentPinSelect (stateQ.segSel),
    .sharedMask       (sharedMask),
    .segFunction      (segFunction),
    .comFunction      (comFunction)
  );

  // Reset sampled low at a clock edge
  sequence reset_low_s;
    !resetn;
  endsequence

  // Read setup aimed at the status word
  sequence status_setup_s;
    psel && !penable && !pwrite && (paddr == OffStatus);
  endsequence

  // Nothing generated while the clock source or the module is off
  AST_GEN_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    (!displayModuleOn || stateQ.osc2) |-> (!pumpOn && !biasGenOn))
    else $error("generation active while disabled");

  // External supply: capacitor pin feeds the peak voltage, pump off
  AST_EXT_SUP: assert property (@(posedge core_clk) disable iff (!resetn)
    externalSupplySelect |-> (!pumpOn && supplyFromCapPin && !supplyFromMain))
    else $error("pump on with external supply");

  // Zero level never selects the pump
  AST_MAIN: assert property (@(posedge core_clk) disable iff (!resetn)
    (pumpVoltageLevel == '0) |-> !supplyFromPump)
    else $error("pump source with zero level");

  // Pump source only with internal supply, pump enabled and generation on
  AST_PUMP_SRC: assert property (@(posedge core_clk) disable iff (!resetn)
    supplyFromPump |-> (!externalSupplySelect && pumpEnableCfg && genEnable))
    else $error("pump source without its conditions");

  // Static mode keeps the divider off
  AST_STATIC: assert property (@(posedge core_clk) disable iff (!resetn)
    (multiplexMode == MuxStatic) |-> !biasGenOn)
    else $error("divider on in static mode");

  // Half or third bias follows the select bit while the divider runs
  AST_HALF: assert property (@(posedge core_clk) disable iff (!resetn)
    ((multiplexMode != MuxStatic) && biasGenOn) |-> (biasHalf == halfBiasSelect))
    else $error("bias ratio not following select");

  // External bias turns the internal generator off
  AST_EXTBIAS: assert property (@(posedge core_clk) disable iff (!resetn)
    externalBiasEnable |-> (!biasGenOn && biasPinsIn))
    else $error("internal bias with external bias");

  // Internal levels reach the pins when asked and generated
  AST_BIAS_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    (biasOutputEnable && biasGenOn) |-> biasPinsOut)
    else $error("bias levels not routed out");

  // Low level taken from its pin when selected
  AST_LOW_EXT: assert property (@(posedge core_clk) disable iff (!resetn)
    lowBiasExt |-> lowBiasExternal)
    else $error("low bias level not external");

  // Bias pins in use block the external pump reference
  AST_REF_BLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    (biasOutputEnable || externalBiasEnable || (pumpReferenceSelect != PumpRefExt))
      |-> !pumpRefExternal)
    else $error("external reference taken while blocked");

  // Ladder top never driven while it is the supply input
  AST_TOP_DIR: assert property (@(posedge core_clk) disable iff (!resetn)
    externalSupplySelect |-> !ladderTopDrive)
    else $error("ladder top driven with external supply");

  // Flag is the interrupt request only with its enable
  AST_IRQ: assert property (@(posedge core_clk) disable iff (!resetn)
    missingCapIrq == (missingCapFlag && missingCapIrqEnable))
    else $error("interrupt gating wrong");

  // Masked flag never raises a request
  AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (!resetn)
    !missingCapIrqEnable |-> !missingCapIrq)
    else $error("masked flag raised a request");

  // Status read returns the flag as it stood at setup
  AST_STATUS_RD: assert property (@(posedge core_clk) disable iff (!resetn)
    status_setup_s |=> (prdata[StatCapFlagBit] == $past(missingCapFlag)))
    else $error("status read lost the flag");

  // Control write lands at the access edge
  AST_WR_CTRL: assert property (@(posedge core_clk) disable iff (!resetn)
    (access && pwrite && paddr == OffCtrl) |=> (stateQ.ctrl == $past(pwdata)))
    else $error("control write lost");

  // Reset clears every control word
  AST_RESET_CLEAR: assert property (@(posedge core_clk)
    reset_low_s |=> ((stateQ.ctrl == '0) && (stateQ.segSel == '0) && (stateQ.suspendSel == '0)))
    else $error("control bits not cleared by reset");

  // Four commons take all three shared pins
  AST_COM: assert property (@(posedge core_clk) disable iff (!resetn)
    (multiplexMode == Mux4) |-> (segFunction[ComSegLsb +: 3] == 3'h0))
    else $error("common not taking precedence");

  // A needed common line never also shows as segment
  AST_COM_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
    (segFunction[ComSegLsb +: 3] & comFunction) == 3'h0)
    else $error("segment and common on one pin");

  // Shared pin with select low is general I/O
  AST_SHARED_IO: assert property (@(posedge core_clk) disable iff (!resetn)
    ((sharedMask & ~stateQ.segSel) & segFunction) == '0)
    else $error("shared pin not general I/O");

  // Shared pin with select high is segment unless a common needs it
  AST_SHARED_SEG: assert property (@(posedge core_clk) disable iff (!resetn)
    ((sharedMask & stateQ.segSel & ~(SegW'(comFunction) << ComSegLsb)) & ~segFunction) == '0)
    else $error("shared pin not segment");

  // Dedicated pins not needed by a common stay segment whatever the select word says
  AST_DEDICATED: assert property (@(posedge core_clk) disable iff (!resetn)
    ((~sharedMask) & (~segFunction) & (~(SegW'(comFunction) << ComSegLsb))) == '0)
    else $error("dedicated pin left segment function");
endmodule // supply_bias_ctrl

// *** design/supply_bias_pkg.sv ***
// Package: register map, field layout and widths of the supply and bias control block
package supply_bias_pkg;
  localparam int         AddrW          = 12;
  localparam logic [11:0] OffCtrl        = 12'h000;
  localparam logic [11:0] OffPump        = 12'h004;
  localparam logic [11:0] OffSegSel      = 12'h008;
  localparam logic [11:0] OffStatus      = 12'h00C;
  // Control register fields
  localparam int         CtrlModuleOnBit = 0;
  localparam int         CtrlExtSupBit   = 1;
  localparam int         CtrlPumpEnBit   = 2;
  localparam int         CtrlBiasOutBit  = 3;
  localparam int         CtrlExtBiasBit  = 4;
  localparam int         CtrlLowExtBit   = 5;
  localparam int         CtrlHalfBiasBit = 6;
  localparam int         CtrlCapIeBit    = 7;
  localparam int         CtrlMuxLsb      = 8;
  localparam int         CtrlLevelLsb    = 12;
  localparam int         CtrlRefLsb      = 16;
  localparam int         CtrlPumpRefLsb  = 18;
  localparam int         MuxW            = 2;
  localparam int         LevelW          = 4;
  localparam int         RefW            = 2;
  localparam int         SuspendW        = 4;
  localparam int         SegW            = 32;
  localparam logic [1:0] MuxStatic       = 2'h0;
  localparam logic [1:0] Mux2            = 2'h1;
  localparam logic [1:0] Mux3            = 2'h2;
  localparam logic [1:0] Mux4            = 2'h3;
  localparam logic [1:0] PumpRefExt      = 2'h1;
  localparam logic [31:0] ResetWord      = 32'h0000_0000;
  // Lowest segment index that doubles as common lines 1 to 3
  localparam int         ComSegLsb       = 1;
  // Status fields
  localparam int         StatCapFlagBit  = 0;
  localparam int         StatPumpOnBit   = 1;
  localparam int         StatVoltOnBit   = 2;
endpackage

// *** test/lcd_glass_model.sv ***
// Far-side model: display glass, pump capacitor and shared pin wiring
`timescale 1ns/10ps
module lcd_glass_model
#(
  parameter logic [31:0] SharedPins = 32'h0000_F0FE
)
(
  input  wire logic                         capFitted,
  output logic                              capSense,
  output logic [supply_bias_pkg::SegW-1:0]  sharedMask
);
  import supply_bias_pkg::*;
  // Capacitor presence shows as a steady level on the pump pin
  assign capSense = capFitted;
  // Board wiring is fixed; bit 0 stays a dedicated segment pin
  assign sharedMask = SharedPins;
endmodule // lcd_glass_model

// *** test/tb.sv ***
// Self-checking bench for the supply, bias and pin-function block
`timescale 1ns/10ps
module tb;
  import supply_bias_pkg::*;
  localparam logic [31:0] OnB = 32'h1 << CtrlModuleOnBit;
  localparam logic [31:0] ExtB = 32'h1 << CtrlExtSupBit;
  localparam logic [31:0] PenB = 32'h1 << CtrlPumpEnBit;
  localparam logic [31:0] BoutB = 32'h1 << CtrlBiasOutBit;
  localparam logic [31:0] EbB = 32'h1 << CtrlExtBiasBit;
  localparam logic [31:0] LowB = 32'h1 << CtrlLowExtBit;
  localparam logic [31:0] HalfB = 32'h1 << CtrlHalfBiasBit;
  localparam logic [31:0] IeB = 32'h1 << CtrlCapIeBit;
  localparam logic [31:0] Lv5 = 32'h5 << CtrlLevelLsb;
  localparam logic [31:0] PrefB = 32'h1 << CtrlPumpRefLsb;
  localparam logic [31:0] Mux2B = 32'h1 << CtrlMuxLsb;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic oscDisabled, capFitted, capSense;
  logic [AddrW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [SuspendW-1:0] suspendPeriod;
  logic [SegW-1:0] sharedMask, segFunction;
  logic supplyFromMain, supplyFromPump, supplyFromCapPin, pumpOn, pumpRefExternal;
  logic biasGenOn, biasHalf, biasPinsOut, biasPinsIn, lowBiasExternal;
  logic ladderTopDrive, ladderTopInput, missingCapFlag, missingCapIrq;
  logic [LevelW-1:0] pumpLevelOut;
  logic [2:0] comFunction;
  int failures, checked;

  supply_bias_ctrl dut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .oscDisabled, .capSense, .suspendPeriod, .sharedMask,
    .supplyFromMain, .supplyFromPump, .supplyFromCapPin, .pumpOn, .pumpLevelOut,
    .pumpRefExternal, .biasGenOn, .biasHalf, .biasPinsOut, .biasPinsIn, .lowBiasExternal,
    .ladderTopDrive, .ladderTopInput, .segFunction, .comFunction, .missingCapFlag,
    .missingCapIrq);
  lcd_glass_model glass (.capFitted, .capSense, .sharedMask);

  // Clock at 250 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; waits on pready rather than assuming its latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge core_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lets the two-stage input synchronisers and the pump guard catch up
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic ctl(input logic [31:0] d);
    apb(1'b1, OffCtrl, d);
    settle();
  endtask

  task automatic t_reset();
    apb(1'b0, OffCtrl, 0);
    check("ctrl", rd, ResetWord);
    check("ready", pready, 1);
    check("fromMain", supplyFromMain, 1);
    check("segFn", segFunction, ~sharedMask);
    check("genOff", {pumpOn, biasGenOn}, 0);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    check("wrErr", err, 1);
    apb(1'b0, 12'h010, 0);
    check("rdErr", {err, rd}, {1'b1, 32'h0});
    apb(1'b0, OffCtrl, 0);
    check("ctrlKept", rd, 0);
    $display("test reset done");
  endtask

  task automatic t_pump();
    ctl(OnB | PenB | Lv5);
    check("pump", {supplyFromPump, supplyFromMain, pumpOn}, 3'b101);
    check("level", pumpLevelOut, 5);
    // Contrast step through the level field
    ctl(OnB | PenB | (32'h9 << CtrlLevelLsb));
    check("level9", pumpLevelOut, 9);
    apb(1'b0, OffStatus, 0);
    check("status", rd[2:0], 3'b110);
    ctl(OnB | Lv5);
    check("stopped", pumpOn, 0);
    ctl(OnB | PenB | Lv5);
    check("resumed", pumpOn, 1);
    apb(1'b1, OffPump, 32'h2);
    suspendPeriod <= 4'h2;
    settle();
    check("suspend", pumpOn, 0);
    @(posedge core_clk);
    suspendPeriod <= 4'h1;
    settle();
    check("unselected", pumpOn, 1);
    apb(1'b1, OffPump, 0);
    $display("test pump done");
  endtask

  task automatic t_gate();
    ctl(OnB | PenB | Lv5 | (32'h1 << CtrlMuxLsb));
    @(posedge core_clk);
    oscDisabled <= 1'b1;
    settle();
    check("osc_disabled", {pumpOn, biasGenOn}, 0);
    @(posedge core_clk);
    oscDisabled <= 1'b0;
    settle();
    check("oscOn", {pumpOn, biasGenOn}, 2'b11);
    ctl(PenB | Lv5 | (32'h1 << CtrlMuxLsb));
    check("modOff", {pumpOn, biasGenOn}, 0);
    $display("test gate done");
  endtask

  task automatic t_bias();
    // Pump with an external divider only at half bias on shared-pin parts
    ctl(OnB | ExtB | PenB | Lv5 | EbB | HalfB | Mux2B);
    check("extSup", {supplyFromCapPin, supplyFromPump, pumpOn}, 3'b100);
    check("topIn", {ladderTopInput, ladderTopDrive}, 2'b10);
    check("extBias", {biasPinsIn, biasGenOn}, 2'b10);
    ctl(OnB | PenB | Lv5 | EbB | HalfB | Mux2B);
    check("topOut", {ladderTopInput, ladderTopDrive, supplyFromCapPin}, 3'b010);
    // Reference choice only counts while the pump runs; bias levels need a mux mode
    ctl(OnB | PenB | Lv5 | PrefB | Mux2B);
    check("refExt", {pumpOn, pumpRefExternal}, 2'b11);
    ctl(OnB | PenB | Lv5 | PrefB | BoutB | Mux2B);
    check("biasOut", {biasPinsOut, pumpRefExternal}, 2'b10);
    ctl(OnB | PenB | Lv5 | PrefB | LowB | EbB | HalfB | Mux2B);
    check("lowExt", {lowBiasExternal, pumpRefExternal}, 2'b10);
    ctl(OnB | PenB | Lv5 | (32'h2 << CtrlPumpRefLsb));
    check("refInt", {pumpOn, pumpRefExternal}, 2'b10);
    ctl(OnB | (32'h1 << CtrlRefLsb));
    check("refMain", supplyFromMain, 0);
    $display("test bias done");
  endtask

  task automatic t_mux();
    logic [31:0] sel, exp;
    for (int m = 0; m < 4; m++)
      for (int h = 0; h < 2; h++)
      begin
        sel = m[0] ? 32'h0000_00AA : 32'hFFFF_FF55;
        apb(1'b1, OffSegSel, sel);
        ctl(OnB | (32'(m) << CtrlMuxLsb) | (h ? HalfB : 0));
        exp = (sharedMask & sel) | ~sharedMask;
        for (int i = 0; i < 3; i++)
          if (m > i) exp[ComSegLsb + i] = 1'b0;
        check("biasGen", biasGenOn, m != 0);
        if (m != 0) check("half", biasHalf, h[0]);
        check("com", comFunction, (32'h1 << m) - 32'h1);
        check("seg", segFunction, exp);
      end
    $display("test mux done");
  endtask

  task automatic t_flag();
    @(posedge core_clk);
    capFitted <= 1'b0;
    ctl(OnB | PenB | Lv5 | IeB);
    check("flag", {missingCapFlag, pumpOn, missingCapIrq}, 3'b101);
    ctl(OnB | PenB | Lv5);
    check("irqMasked", {missingCapFlag, missingCapIrq}, 2'b10);
    @(posedge core_clk);
    capFitted <= 1'b1;
    settle();
    check("latched", pumpOn, 0);
    apb(1'b1, OffStatus, 32'h1);
    settle();
    check("cleared", {missingCapFlag, pumpOn}, 2'b01);
    $display("test flag done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence; inputs settled at time zero, reset held three cycles
  initial
  begin
    {psel, penable, pwrite, oscDisabled} = 0;
    {paddr, pwdata, suspendPeriod} = 0;
    resetn = 1'b0;
    capFitted = 1'b1;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_pump();
    t_gate();
    t_bias();
    t_mux();
    t_flag();
    report_and_stop();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
endmodule // tb
